// ---- logic/icb_counter.sv ----
// Interval counter with match, auto-clear and read freeze interlock.
`timescale 1ns/1ps
module icb_counter #(
   parameter int W = 18
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Control
   input  wire logic         enable,
   input  wire logic         step,
   input  wire logic         clear,
   input  wire logic         freeze,
   input  wire logic [W-1:0] interval,
   // Results
   output logic [W-1:0]      count,
   output logic              match
);
   logic [2:0] owed;
   logic       apply;
   logic [W-1:0] next_count;

   // A step taken while frozen is owed and applied in the cycle after the freeze.
   assign apply = !freeze && (step || owed != 3'h0);
   assign next_count = count + {{(W-1){1'b0}}, 1'b1};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         owed <= 3'h0;
      end else if (clear || !enable) begin
         owed <= 3'h0;
      end else if (freeze && step && owed != 3'h7) begin
         owed <= owed + 3'h1;
      end else if (!freeze && owed != 3'h0 && !step) begin
         owed <= owed - 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         match <= 1'b0;
      end else if (clear || !enable) begin
         count <= '0;
         match <= 1'b0;
      end else if (apply) begin
         // Continuous compare on each count; match restarts the interval.
         if (next_count == interval) begin
            count <= '0;
            match <= 1'b1;
         end else begin
            count <= next_count;
            match <= 1'b0;
         end
      end else begin
         match <= 1'b0;
      end
   end
endmodule : icb_counter

// ---- logic/icb_pkg.sv ----
// Package of constants and types for the interval clock time base.
package icb_pkg;
   // =========================================================================
   // Timing
   // =========================================================================
   localparam int  CLK_MHZ        = 100;
   localparam int  TICK_US        = 1;
   localparam int  TICK_CYCLES    = CLK_MHZ * TICK_US;
   localparam int  REF_US         = 10;
   localparam int  REF_CYCLES     = CLK_MHZ * REF_US;
   localparam int  EXT_MAX_KHZ    = 400;
   localparam int  EXT_MIN_CYCLES = (CLK_MHZ * 1000) / EXT_MAX_KHZ;
   // =========================================================================
   // Widths
   // =========================================================================
   localparam int  IVL_W   = 18;
   localparam int  CHAN_W  = 3;
   localparam int  TB_W    = 60;
   // =========================================================================
   // Register byte offsets
   // =========================================================================
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_IVL      = 8'h04;
   localparam logic [7:0] OFS_CNT      = 8'h08;
   localparam logic [7:0] OFS_TIVL     = 8'h0c;
   localparam logic [7:0] OFS_TCNT     = 8'h10;
   localparam logic [7:0] OFS_TB_LO    = 8'h14;
   localparam logic [7:0] OFS_TB_HI    = 8'h18;
   localparam logic [7:0] OFS_STATUS   = 8'h1c;
   localparam logic [7:0] OFS_MASK     = 8'h20;
   localparam logic [7:0] OFS_DEVCODE  = 8'h24;
   // =========================================================================
   // Control fields
   // =========================================================================
   localparam int  CTRL_CLK_EN   = 0;
   localparam int  CTRL_EXT_SEL  = 1;
   localparam int  CTRL_TMR_EN   = 2;
   localparam int  CTRL_CHAN_LSB = 4;
   localparam int  CTRL_TCHAN_LSB = 8;
   localparam int  ST_CLK        = 0;
   localparam int  ST_TMR        = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0]  MASK_RESET = 2'h0;
   localparam logic [1:0]  DEVCODE_RESET = 2'h0;
   // Arbitrary device codes chosen for this design.
   localparam logic [6:0] DEV_CODE_A = 7'h10;
   localparam logic [6:0] DEV_CODE_B = 7'h11;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic                clk_en;
      logic                ext_sel;
      logic                tmr_en;
      logic [CHAN_W-1:0]   chan;
      logic [CHAN_W-1:0]   tchan;
   } icb_ctrl_type;

   typedef enum logic [1:0] {
      ICB_IDLE  = 2'b00,
      ICB_FREEZE = 2'b01,
      ICB_SEND  = 2'b11
   } icb_rd_type;
endpackage : icb_pkg

// ---- logic/icb_top.sv ----
// Interval clock, microsecond timer and time base with AXI4-Lite access.
// Functional notes
// - Interval clock counts 10 us steps with an 18-bit interval setting.
// - Steps come from a 100 kHz reference or external pulses to 400 kHz.
// - Counter is compared against the interval on every count.
// - A match raises a program interrupt request.
// - The same match clears the counter by itself.
// - Software picks the interrupt channel for the match.
// - Device answers at either of two selectable device codes.
// - Reads freeze the counter for one cycle; a pulse in that cycle is applied in the next.
// - All control and readout goes through the processor I/O path.
// - A one-microsecond tick is divided from the machine clock.
// - Internal timer interrupts periodically with 1 us resolution.
// - Time base is a free-running 60-bit microsecond counter.
`timescale 1ns/1ps
module icb_top (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // External count pulse pin
   input  wire logic         ext_pulse,
   // AXI4-Lite write address
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // Interrupts
   output logic              irq,
   output logic [7:0]        irq_chan,
   output logic [6:0]        dev_code
);
   // ========================================================================
   // Declarations
   // ========================================================================
   icb_pkg::icb_ctrl_type ctrl;
   icb_pkg::icb_rd_type   rd_state;
   logic [17:0]  ivl;
   logic [17:0]  tivl;
   logic [17:0]  cnt;
   logic [17:0]  tcnt;
   logic [59:0]  time_base;
   logic [27:0]  tb_hi_latch;
   logic [1:0]   status;
   logic [1:0]   mask;
   logic         dev_sel;
   logic [6:0]   us_div;
   logic [9:0]   ref_div;
   logic         us_tick;
   logic         ref_tick;
   logic [2:0]   ext_sync;
   logic         ext_edge;
   logic         clk_step;
   logic         clk_match;
   logic         tmr_match;
   logic         freeze;
   logic         aw_held;
   logic         w_held;
   logic [7:0]   aw_addr;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         wr_go;
   logic [7:0]   ar_addr;
   logic [31:0]  next_rdata;
   logic [1:0]   next_rresp;
   logic [1:0]   clr_bits;
   logic [31:0]  wmask;

   // ========================================================================
   // Tick dividers
   // ========================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         us_div  <= 7'h00;
         us_tick <= 1'b0;
      end else if (us_div == 7'(icb_pkg::TICK_CYCLES - 1)) begin
         us_div  <= 7'h00;
         us_tick <= 1'b1;
      end else begin
         us_div  <= us_div + 7'h01;
         us_tick <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_div  <= 10'h000;
         ref_tick <= 1'b0;
      end else if (ref_div == 10'(icb_pkg::REF_CYCLES - 1)) begin
         ref_div  <= 10'h000;
         ref_tick <= 1'b1;
      end else begin
         ref_div  <= ref_div + 10'h001;
         ref_tick <= 1'b0;
      end
   end

   // ========================================================================
   // External pulse input
   // ========================================================================
   // Two stages settle the pin; the third only feeds the edge detector.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], ext_pulse};
      end
   end
   assign ext_edge = ext_sync[1] && !ext_sync[2];

   // Source select: internal reference or external pulse stream.
   assign clk_step = ctrl.ext_sel ? ext_edge : ref_tick;

   // ========================================================================
   // Counters
   // ========================================================================
   icb_counter #(
      .W (icb_pkg::IVL_W)
   ) u_clk (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .enable   (ctrl.clk_en),
      .step     (clk_step),
      .clear    (1'b0),
      .freeze   (freeze),
      .interval (ivl),
      .count    (cnt),
      .match    (clk_match)
   );

   icb_counter #(
      .W (icb_pkg::IVL_W)
   ) u_tmr (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .enable   (ctrl.tmr_en),
      .step     (us_tick),
      .clear    (1'b0),
      .freeze   (freeze),
      .interval (tivl),
      .count    (tcnt),
      .match    (tmr_match)
   );

   // Time base never stops; high word is latched when the low word is read.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         time_base <= 60'h0;
      end else if (us_tick) begin
         time_base <= time_base + 60'h1;
      end
   end

   // ========================================================================
   // Interrupts
   // ========================================================================
   assign clr_bits = (wr_go && aw_addr == icb_pkg::OFS_STATUS && w_strb[0])
                     ? w_data[1:0] : 2'h0;

   // A match in the clearing cycle survives the clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= 2'h0;
      end else begin
         status <= (status & ~clr_bits) | {tmr_match, clk_match};
      end
   end

   assign irq = |(status & mask);

   // Each source drives the one channel line that software chose.
   always_comb begin
      irq_chan = 8'h00;
      if (status[icb_pkg::ST_CLK] && mask[icb_pkg::ST_CLK]) begin
         irq_chan[ctrl.chan] = 1'b1;
      end
      if (status[icb_pkg::ST_TMR] && mask[icb_pkg::ST_TMR]) begin
         irq_chan[ctrl.tchan] = 1'b1;
      end
   end

   assign dev_code = dev_sel ? icb_pkg::DEV_CODE_B
                             : icb_pkg::DEV_CODE_A;

   // ========================================================================
   // AXI4-Lite write path
   // ========================================================================
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   always_comb begin
      wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   end

   // Registers are reached only through the processor bus path.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl    <= icb_ctrl_reset();
         ivl     <= 18'h0;
         tivl    <= 18'h0;
         mask    <= icb_pkg::MASK_RESET;
         dev_sel <= 1'b0;
      end else if (wr_go) begin
         unique case (aw_addr)
            icb_pkg::OFS_CTRL: begin
               ctrl <= icb_ctrl_decode(w_data & wmask);
            end
            icb_pkg::OFS_IVL: begin
               ivl <= (w_data[17:0] & wmask[17:0]) | (ivl & ~wmask[17:0]);
            end
            icb_pkg::OFS_TIVL: begin
               tivl <= (w_data[17:0] & wmask[17:0]) | (tivl & ~wmask[17:0]);
            end
            icb_pkg::OFS_MASK: begin
               if (w_strb[0]) mask <= w_data[1:0];
            end
            icb_pkg::OFS_DEVCODE: begin
               if (w_strb[0]) dev_sel <= w_data[0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= icb_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= icb_addr_ok(aw_addr) ? icb_pkg::RESP_OKAY
                                              : icb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ========================================================================
   // AXI4-Lite read path with counter freeze
   // ========================================================================
   assign s_axi_arready = (rd_state == icb_pkg::ICB_IDLE);
   assign freeze = (rd_state == icb_pkg::ICB_FREEZE);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= icb_pkg::ICB_IDLE;
         ar_addr  <= 8'h00;
      end else begin
         unique case (rd_state)
            icb_pkg::ICB_IDLE: begin
               if (s_axi_arvalid) begin
                  ar_addr  <= s_axi_araddr;
                  rd_state <= icb_pkg::ICB_FREEZE;
               end
            end
            icb_pkg::ICB_FREEZE: begin
               rd_state <= icb_pkg::ICB_SEND;
            end
            icb_pkg::ICB_SEND: begin
               if (s_axi_rready) rd_state <= icb_pkg::ICB_IDLE;
            end
            default: begin
               rd_state <= icb_pkg::ICB_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      next_rresp = icb_pkg::RESP_OKAY;
      unique case (ar_addr)
         icb_pkg::OFS_CTRL:    next_rdata = icb_ctrl_encode(ctrl);
         icb_pkg::OFS_IVL:     next_rdata = {14'h0, ivl};
         icb_pkg::OFS_CNT:     next_rdata = {14'h0, cnt};
         icb_pkg::OFS_TIVL:    next_rdata = {14'h0, tivl};
         icb_pkg::OFS_TCNT:    next_rdata = {14'h0, tcnt};
         icb_pkg::OFS_TB_LO:   next_rdata = time_base[31:0];
         icb_pkg::OFS_TB_HI:   next_rdata = {4'h0, tb_hi_latch};
         icb_pkg::OFS_STATUS:  next_rdata = {30'h0, status};
         icb_pkg::OFS_MASK:    next_rdata = {30'h0, mask};
         icb_pkg::OFS_DEVCODE: next_rdata = {31'h0, dev_sel};
         default: begin
            next_rdata = 32'h0;
            next_rresp = icb_pkg::RESP_SLVERR;
         end
      endcase
   end

   // Data is captured in the freeze cycle, so the count is stable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= icb_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         tb_hi_latch <= 28'h0;
      end else if (rd_state == icb_pkg::ICB_FREEZE) begin
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
         s_axi_rvalid <= 1'b1;
         if (ar_addr == icb_pkg::OFS_TB_LO) tb_hi_latch <= time_base[59:32];
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ========================================================================
   // Helpers
   // ========================================================================
   function automatic icb_pkg::icb_ctrl_type icb_ctrl_decode(
      input logic [31:0] d
   );
      icb_pkg::icb_ctrl_type c;
      c.clk_en  = d[icb_pkg::CTRL_CLK_EN];
      c.ext_sel = d[icb_pkg::CTRL_EXT_SEL];
      c.tmr_en  = d[icb_pkg::CTRL_TMR_EN];
      c.chan    = d[icb_pkg::CTRL_CHAN_LSB +: icb_pkg::CHAN_W];
      c.tchan   = d[icb_pkg::CTRL_TCHAN_LSB +: icb_pkg::CHAN_W];
      return c;
   endfunction : icb_ctrl_decode

   function automatic logic [31:0] icb_ctrl_encode(
      input icb_pkg::icb_ctrl_type c
   );
      logic [31:0] d;
      d = 32'h0;
      d[icb_pkg::CTRL_CLK_EN]  = c.clk_en;
      d[icb_pkg::CTRL_EXT_SEL] = c.ext_sel;
      d[icb_pkg::CTRL_TMR_EN]  = c.tmr_en;
      d[icb_pkg::CTRL_CHAN_LSB +: icb_pkg::CHAN_W]  = c.chan;
      d[icb_pkg::CTRL_TCHAN_LSB +: icb_pkg::CHAN_W] = c.tchan;
      return d;
   endfunction : icb_ctrl_encode

   function automatic icb_pkg::icb_ctrl_type icb_ctrl_reset();
      return icb_ctrl_decode(icb_pkg::CTRL_RESET);
   endfunction : icb_ctrl_reset

   function automatic logic icb_addr_ok(input logic [7:0] a);
      return a <= icb_pkg::OFS_DEVCODE && a[1:0] == 2'b00;
   endfunction : icb_addr_ok
endmodule : icb_top

// ---- testbench/icb_assertions.sv ----
// Port assertions for the interval clock time base.
`timescale 1ns/1ps
module icb_checker (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Interrupts
   input wire logic        irq,
   input wire logic [7:0]  irq_chan,
   input wire logic [6:0]  dev_code
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // =====================================================================
   // Assertions
   // =====================================================================
   chk_irq_chan_tie: assert property (irq == (irq_chan != 8'h00))
      else $error("irq and channel lines disagree");
   chk_read_latency: assert property (s_axi_arvalid && s_axi_arready
      |=> !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer late");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while busy");
   chk_write_latency: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write answer late");
   chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
   chk_write_refuse: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("write taken busy");
   chk_dev_code_legal: assert property (
      dev_code == icb_pkg::DEV_CODE_A || dev_code == icb_pkg::DEV_CODE_B)
      else $error("bad device code");
   cover property ($rose(irq));
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (s_axi_bvalid && s_axi_bresp == icb_pkg::RESP_SLVERR);
endmodule : icb_checker

bind icb_top icb_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq, .irq_chan, .dev_code);

// ---- testbench/icb_bench.sv ----
// Self-checking bench for the interval clock time base.
`timescale 1ns/1ps
module icb_bench;
   logic        aclk, aresetn, ext_pulse, go, busy, irq;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [3:0]  s_axi_wstrb;
   logic [6:0]  dev_code;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_chan, n_pulses;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   int          n_fail = 0, n_checks = 0, cyc = 0, t1, t2, n;

   icb_top DUT (.aclk, .aresetn, .ext_pulse, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .irq_chan,
      .dev_code);
   icb_pulse_src SRC (.aclk, .go, .n_pulses, .ext_pulse, .busy);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;
   // =====================================================================
   // Tasks
   // =====================================================================
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   // One bounded clock step; a wait that runs out ends the run.
   task automatic stall;
      @(posedge aclk);
      n++;
      if (n > 5000) begin
         n_fail++;
         $display("unexpected at %0t: wait ran out", $time);
         test_done();
      end
   endtask : stall

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         stall();
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         stall();
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      axi_write(a, v);
      check(32'(r), 32'(icb_pkg::RESP_OKAY));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] v);
      axi_read(a);
      check(d, v);
      check(32'(r), 32'(icb_pkg::RESP_OKAY));
   endtask : rd

   task automatic wait_irq(output int t);
      n = 0;
      while (irq !== 1'b1) stall();
      t = cyc;
   endtask : wait_irq

   task automatic pulses(input logic [7:0] k);
      n_pulses <= k;
      go       <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
   endtask : pulses
   // =====================================================================
   // Sequence
   // =====================================================================
   initial begin
      {aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
      {s_axi_arvalid, s_axi_rready, n_pulses} = 10'h000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(icb_pkg::OFS_CTRL, icb_pkg::CTRL_RESET);
      check(32'(dev_code), 32'(icb_pkg::DEV_CODE_A));
      wr(icb_pkg::OFS_DEVCODE, 32'h1);
      check(32'(dev_code), 32'(icb_pkg::DEV_CODE_B));
      axi_read(8'h3c);
      check(32'(r), 32'(icb_pkg::RESP_SLVERR));
      axi_write(8'h3c, 32'h1);
      check(32'(r), 32'(icb_pkg::RESP_SLVERR));
      // Microsecond timer on channel 5, period of three ticks.
      wr(icb_pkg::OFS_TIVL, 32'h3);
      wr(icb_pkg::OFS_MASK, 32'h2);
      wr(icb_pkg::OFS_CTRL, 32'h0000_0504);
      wait_irq(t1);
      check(32'(irq_chan), 32'h20);
      rd(icb_pkg::OFS_STATUS, 32'h2);
      wr(icb_pkg::OFS_STATUS, 32'h2);
      wait_irq(t2);
      check(32'(t2 - t1), 32'(3 * icb_pkg::TICK_CYCLES));
      wr(icb_pkg::OFS_MASK, 32'h0);
      repeat (400) @(posedge aclk);
      check(32'(irq), 32'h0);
      rd(icb_pkg::OFS_STATUS, 32'h2);
      wr(icb_pkg::OFS_CTRL, 32'h0);
      wr(icb_pkg::OFS_STATUS, 32'h3);
      // Interval clock on the internal reference, channel 3.
      wr(icb_pkg::OFS_IVL, 32'h2);
      wr(icb_pkg::OFS_MASK, 32'h1);
      wr(icb_pkg::OFS_CTRL, 32'h0000_0031);
      wait_irq(t1);
      check(32'(irq_chan), 32'h08);
      wr(icb_pkg::OFS_STATUS, 32'h1);
      wait_irq(t2);
      check(32'(t2 - t1), 32'(2 * icb_pkg::REF_CYCLES));
      wr(icb_pkg::OFS_CTRL, 32'h0);
      wr(icb_pkg::OFS_STATUS, 32'h3);
      // External pulses, read continuously while they arrive.
      wr(icb_pkg::OFS_IVL, 32'h5);
      wr(icb_pkg::OFS_CTRL, 32'h0000_0033);
      pulses(8'd4);
      // One idle edge puts some read freezes on the very cycle of a count.
      @(posedge aclk);
      for (int i = 0; i < 400 && busy === 1'b1; i++)
         axi_read(icb_pkg::OFS_CNT);
      if (busy !== 1'b0) begin
         n_fail++;
         $display("unexpected at %0t: pulse train never ended", $time);
         test_done();
      end
      repeat (8) @(posedge aclk);
      rd(icb_pkg::OFS_CNT, 32'h4);
      check(32'(irq), 32'h0);
      pulses(8'd1);
      wait_irq(t1);
      check(32'(irq_chan), 32'h08);
      rd(icb_pkg::OFS_CNT, 32'h0);
      // Time base advances one count per microsecond.
      t1 = cyc;
      axi_read(icb_pkg::OFS_TB_LO);
      t2 = int'(d);
      while (cyc < t1 + 1000) @(posedge aclk);
      axi_read(icb_pkg::OFS_TB_LO);
      check(d - 32'(t2), 32'(1000 / icb_pkg::TICK_CYCLES));
      rd(icb_pkg::OFS_TB_HI, 32'h0);
      test_done();
   end
endmodule : icb_bench

// ---- testbench/icb_pulse_src.sv ----
// External count pulse source standing at the clock's pulse pin.
`timescale 1ns/1ps
module icb_pulse_src (
   // Clock
   input  wire logic       aclk,
   // Request from the bench
   input  wire logic       go,
   input  wire logic [7:0] n_pulses,
   // Pulse pin and progress
   output logic            ext_pulse,
   output logic            busy
);
   // =====================================================================
   // Pulse train
   // =====================================================================
   // Pulses run at the fastest legal rate so that edge loss would show.
   initial begin
      ext_pulse = 1'b0;
      busy      = 1'b0;
      forever begin
         @(posedge aclk);
         if (go) begin
            busy <= 1'b1;
            repeat (n_pulses) begin
               ext_pulse <= 1'b1;
               repeat (icb_pkg::EXT_MIN_CYCLES / 2) @(posedge aclk);
               ext_pulse <= 1'b0;
               repeat (icb_pkg::EXT_MIN_CYCLES / 2) @(posedge aclk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule : icb_pulse_src
